// [core/sfim_pkg.sv]
`default_nettype none
package sfim_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Instruction codes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_READ4B = 8'h13;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_DTR_READ = 8'h0d;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_ENTER_4L = 8'h38;
   localparam logic [7:0] OP_EXIT_4L = 8'hff;
   localparam logic [7:0] OP_ENTER_4B = 8'hb7;
   localparam logic [7:0] OP_EXIT_4B = 8'he9;
   localparam logic [7:0] OP_SW_RESET = 8'h99;
   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_SYS_NS = 10;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_SYS_NS);
   localparam logic [5:0] DUMMY_CLKS = 6'h08;
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS_3B = 6'h18;
   localparam logic [5:0] ADDR_BITS_4B = 6'h20;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic RST_FOUR_LANE = 1'b0;
   localparam logic RST_ADDR_MODE = 1'b0;
   localparam logic [5:0] RST_PINS = 6'h1f;
   localparam logic [3:0] RST_LANES = 4'hf;
   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {W1 = 2'b00, W2 = 2'b01, W4 = 2'b10} sfim_width_t;
   typedef enum logic [2:0] {
      PH_CMD = 3'b000, PH_ADDR = 3'b001, PH_DUMMY = 3'b010, PH_DATA = 3'b011,
      PH_SKIP = 3'b100, PH_IDLE = 3'b101, PH_END = 3'b110
   } sfim_phase_t;
   // Bits moved per edge for a lane width
   function automatic logic [2:0] sfim_step(input sfim_width_t w);
      return (w == W4) ? 3'h4 : ((w == W2) ? 3'h2 : 3'h1);
   endfunction
endpackage
`default_nettype wire

// [core/sfim_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sfim_link_if;
   logic sclk;
   logic csN;
   logic [3:0] hostOut;
   logic [3:0] hostOe;
   logic [3:0] devOut;
   logic [3:0] devOe;
   wire logic [3:0] lane;
   // Wire level from the enables; an undriven lane floats high
   assign lane = (hostOut & hostOe) | (devOut & devOe) | ~(hostOe | devOe);
   modport host (output sclk, output csN, output hostOut, output hostOe, input lane);
   modport dev (input sclk, input csN, input lane, output devOut, output devOe);
endinterface
`default_nettype wire

// [core/sfim_device.sv]
`timescale 1ns/1ps
`default_nettype none
module sfim_device (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Link
   sfim_link_if.dev link,
   // Non-volatile configuration
   input wire logic quadLaneEnable,
   input wire logic powerUpAddrMode,
   input wire logic [7:0] extAddrReg,
   // Array side
   input wire logic [7:0] readData,
   output logic addrStrobe,
   output logic [31:0] address,
   output logic byteTaken,
   output logic [7:0] activeOp,
   // Status
   output logic fourLaneCommandMode,
   output logic currentAddrMode,
   output logic paused
);
   ////////////////////////////////////////////////////////////////////////////
   logic [5:0] pinS1, pinS2, pinS3, pinF;
   logic sclkPrev, started, drvOn, isDtr;
   logic [31:0] sh;
   logic [5:0] cnt, addrBits;
   logic [7:0] outSh;
   logic [3:0] outLeft, drvOe;
   sfim_pkg::sfim_phase_t state;
   sfim_pkg::sfim_width_t addrW, dataW;
   wire [5:0] pinRaw = {link.sclk, link.csN, link.lane};

   // Three-stage synchroniser per pin, value taken once stages two and three agree
   for (genvar i = 0; i < 6; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            pinS1[i] <= sfim_pkg::RST_PINS[i];
            pinS2[i] <= sfim_pkg::RST_PINS[i];
            pinS3[i] <= sfim_pkg::RST_PINS[i];
            pinF[i] <= sfim_pkg::RST_PINS[i];
         end else if (ce) begin
            pinS1[i] <= pinRaw[i];
            pinS2[i] <= pinS1[i];
            pinS3[i] <= pinS2[i];
            if (pinS2[i] == pinS3[i]) begin
               pinF[i] <= pinS3[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edges and pause
   wire sclkF = pinF[5];
   wire csNF = pinF[4];
   wire [3:0] laneF = pinF[3:0];
   wire rise = sclkF & ~sclkPrev;
   wire fall = ~sclkF & sclkPrev;
   wire holdEn = ~quadLaneEnable & ~fourLaneCommandMode;
   wire holdReq = holdEn & ~csNF & ~laneF[3];
   wire nextPaused = csNF ? 1'b0 : (~sclkF ? holdReq : paused);
   wire live = ~csNF & ~paused;
   wire rEdge = rise & live;
   wire fEdge = fall & live;

   // Input shifting, four-lane nibbles high first
   wire sfim_pkg::sfim_width_t inW = (state == sfim_pkg::PH_CMD) ?
      (fourLaneCommandMode ? sfim_pkg::W4 : sfim_pkg::W1) : addrW;
   wire [31:0] nextSh = (inW == sfim_pkg::W4) ? {sh[27:0], laneF} :
      ((inW == sfim_pkg::W2) ? {sh[29:0], laneF[1:0]} : {sh[30:0], laneF[0]});
   wire [5:0] nextCnt = cnt + {3'h0, sfim_pkg::sfim_step(inW)};

   // Instruction decode
   wire [7:0] op = nextSh[7:0];
   wire opQuad = (op == sfim_pkg::OP_QUAD_OUT) | (op == sfim_pkg::OP_QUAD_IO);
   wire opRead = (op == sfim_pkg::OP_READ) | (op == sfim_pkg::OP_READ4B) | (op == sfim_pkg::OP_FAST) |
      (op == sfim_pkg::OP_DTR_READ) | (op == sfim_pkg::OP_DUAL_OUT) | (op == sfim_pkg::OP_DUAL_IO) | opQuad;
   wire opOk = opRead & (~opQuad | quadLaneEnable);
   wire op4B = (op == sfim_pkg::OP_READ4B);
   wire sfim_pkg::sfim_width_t decAddrW = fourLaneCommandMode ? sfim_pkg::W4 :
      ((op == sfim_pkg::OP_DUAL_IO) ? sfim_pkg::W2 : ((op == sfim_pkg::OP_QUAD_IO) ? sfim_pkg::W4 : sfim_pkg::W1));
   wire sfim_pkg::sfim_width_t decDataW = fourLaneCommandMode ? sfim_pkg::W4 :
      ((op == sfim_pkg::OP_DUAL_IO || op == sfim_pkg::OP_DUAL_OUT) ? sfim_pkg::W2 : (opQuad ? sfim_pkg::W4 : sfim_pkg::W1));
   wire cmdDone = (state == sfim_pkg::PH_CMD) & rEdge & (nextCnt == sfim_pkg::CMD_BITS);
   wire addrEdge = rEdge | (isDtr & fEdge);
   wire addrDone = (state == sfim_pkg::PH_ADDR) & addrEdge & (nextCnt == addrBits);
   wire needDummy = (activeOp != sfim_pkg::OP_READ) & (activeOp != sfim_pkg::OP_READ4B);

   // Output selection
   wire outEdge = fEdge | (isDtr & rEdge & drvOn);
   wire [2:0] outStep = sfim_pkg::sfim_step(dataW);
   wire [7:0] outByte = (outLeft == 4'h0) ? readData : outSh;
   wire [3:0] outBits = (dataW == sfim_pkg::W4) ? outByte[7:4] :
      ((dataW == sfim_pkg::W2) ? {2'b00, outByte[7:6]} : {2'b00, outByte[7], 1'b0});
   wire [3:0] outOe = (dataW == sfim_pkg::W4) ? 4'hf : ((dataW == sfim_pkg::W2) ? 4'h3 : 4'h2);
   wire [3:0] outLeftNext = ((outLeft == 4'h0) ? 4'h8 : outLeft) - {1'b0, outStep};

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer and mode bits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= sfim_pkg::PH_CMD;
         sh <= 32'h0;
         cnt <= 6'h0;
         addrBits <= sfim_pkg::ADDR_BITS_3B;
         addrW <= sfim_pkg::W1;
         dataW <= sfim_pkg::W1;
         isDtr <= 1'b0;
         drvOn <= 1'b0;
         drvOe <= 4'h0;
         outSh <= 8'h0;
         outLeft <= 4'h0;
         sclkPrev <= 1'b0;
         started <= 1'b0;
         paused <= 1'b0;
         addrStrobe <= 1'b0;
         address <= 32'h0;
         byteTaken <= 1'b0;
         activeOp <= 8'h0;
         fourLaneCommandMode <= sfim_pkg::RST_FOUR_LANE;
         currentAddrMode <= sfim_pkg::RST_ADDR_MODE;
         link.devOut <= 4'h0;
         link.devOe <= 4'h0;
      end else if (ce) begin
         sclkPrev <= sclkF;
         paused <= nextPaused;
         addrStrobe <= 1'b0;
         byteTaken <= 1'b0;
         started <= 1'b1;
         if (!started) begin
            currentAddrMode <= powerUpAddrMode;
         end
         // Lanes released when deselected, paused or not yet reading
         link.devOe <= (csNF | nextPaused | ~drvOn) ? 4'h0 : drvOe;
         if (csNF) begin
            state <= sfim_pkg::PH_CMD;
            cnt <= 6'h0;
            drvOn <= 1'b0;
            outLeft <= 4'h0;
            isDtr <= 1'b0;
         end else begin
            case (state)
               sfim_pkg::PH_CMD: begin
                  if (rEdge) begin
                     sh <= nextSh;
                     cnt <= nextCnt;
                  end
                  if (cmdDone) begin
                     cnt <= 6'h0;
                     activeOp <= op;
                     addrW <= decAddrW;
                     dataW <= decDataW;
                     isDtr <= (op == sfim_pkg::OP_DTR_READ);
                     addrBits <= (op4B | currentAddrMode) ? sfim_pkg::ADDR_BITS_4B : sfim_pkg::ADDR_BITS_3B;
                     state <= opOk ? sfim_pkg::PH_ADDR : sfim_pkg::PH_SKIP;
                     if (op == sfim_pkg::OP_ENTER_4L && quadLaneEnable) begin
                        fourLaneCommandMode <= 1'b1;
                     end
                     if (op == sfim_pkg::OP_EXIT_4L) begin
                        fourLaneCommandMode <= 1'b0;
                     end
                     if (op == sfim_pkg::OP_ENTER_4B) begin
                        currentAddrMode <= 1'b1;
                     end
                     if (op == sfim_pkg::OP_EXIT_4B) begin
                        currentAddrMode <= 1'b0;
                     end
                     if (op == sfim_pkg::OP_SW_RESET) begin
                        fourLaneCommandMode <= sfim_pkg::RST_FOUR_LANE;
                        currentAddrMode <= powerUpAddrMode;
                     end
                  end
               end
               sfim_pkg::PH_ADDR: begin
                  if (addrEdge) begin
                     sh <= nextSh;
                     cnt <= nextCnt;
                  end
                  if (addrDone) begin
                     cnt <= 6'h0;
                     addrStrobe <= 1'b1;
                     address <= (addrBits == sfim_pkg::ADDR_BITS_4B) ? nextSh : {extAddrReg, nextSh[23:0]};
                     state <= needDummy ? sfim_pkg::PH_DUMMY : sfim_pkg::PH_DATA;
                  end
               end
               sfim_pkg::PH_DUMMY: begin
                  if (rEdge) begin
                     cnt <= 6'(cnt + 6'h1);
                     if (cnt == sfim_pkg::DUMMY_CLKS - 6'h1) begin
                        cnt <= 6'h0;
                        state <= sfim_pkg::PH_DATA;
                     end
                  end
               end
               sfim_pkg::PH_DATA: begin
                  if (outEdge) begin
                     drvOn <= 1'b1;
                     drvOe <= outOe;
                     link.devOut <= outBits;
                     outSh <= outByte << outStep;
                     outLeft <= outLeftNext;
                     byteTaken <= (outLeft == 4'h0);
                  end
               end
               default: begin
                  state <= state;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [core/sfim_host.sv]
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfim_host #(
   parameter int HALF_DIV = sfim_pkg::LINK_HALF_CYC
) (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Link
   sfim_link_if.host link,
   // Request
   input wire logic start,
   input wire logic [7:0] instr,
   input wire logic [31:0] addr,
   input wire logic [2:0] addrBytes,
   input wire logic cmdWide,
   input wire sfim_pkg::sfim_width_t addrW,
   input wire sfim_pkg::sfim_width_t dataW,
   input wire logic dtr,
   input wire logic [3:0] dummyClks,
   input wire logic [7:0] readBytes,
   input wire logic holdReq,
   // Answer
   output logic busy,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic holdActive
);
   if (HALF_DIV < 8 || HALF_DIV > 255) begin : g_chk
      $error("HALF_DIV must lie in 8..255");
   end
   localparam logic [7:0] DIV_END = 8'(HALF_DIV - 1);
   localparam logic [7:0] DIV_MID = 8'(HALF_DIV / 2 - 1);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] lS1, lS2, lS3, lF;
   logic [7:0] div, rxSh;
   logic [39:0] txSh;
   logic [11:0] cnt;
   logic [3:0] rxBits, dummyR;
   logic [7:0] bytesR;
   logic [2:0] addrBytesR;
   logic cmdWideR, dtrR, rxDue, dataSeen;
   logic [7:0] resumeWait;
   sfim_pkg::sfim_width_t addrWR, dataWR;
   sfim_pkg::sfim_phase_t state;

   // Lane synchroniser, value taken once stages two and three agree
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            lS1[i] <= 1'b1;
            lS2[i] <= 1'b1;
            lS3[i] <= 1'b1;
            lF[i] <= 1'b1;
         end else if (ce) begin
            lS1[i] <= link.lane[i];
            lS2[i] <= lS1[i];
            lS3[i] <= lS2[i];
            if (lS2[i] == lS3[i]) begin
               lF[i] <= lS3[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Beat timing and lane selection
   wire run = busy & ~holdActive & (resumeWait == 8'h0);
   wire endTick = run & (div == DIV_END);
   wire midTick = run & (div == DIV_MID);
   wire quadUse = cmdWideR | (addrWR == sfim_pkg::W4) | (dataWR == sfim_pkg::W4);
   wire txPhase = (state == sfim_pkg::PH_CMD) | (state == sfim_pkg::PH_ADDR);
   wire beat = ~link.sclk | (dtrR & ((state == sfim_pkg::PH_ADDR) | ((state == sfim_pkg::PH_DATA) & dataSeen)));
   wire sfim_pkg::sfim_width_t curW = (state == sfim_pkg::PH_CMD) ? (cmdWideR ? sfim_pkg::W4 : sfim_pkg::W1) : addrWR;
   wire [2:0] txStep = sfim_pkg::sfim_step(curW);
   wire [3:0] txBits = (curW == sfim_pkg::W4) ? txSh[39:36] :
      ((curW == sfim_pkg::W2) ? {2'b00, txSh[39:38]} : {3'b000, txSh[39]});
   wire [3:0] txOe = (curW == sfim_pkg::W4) ? 4'hf : ((curW == sfim_pkg::W2) ? 4'h3 : 4'h1);
   wire [2:0] rxStep = sfim_pkg::sfim_step(dataWR);
   wire [7:0] rxNext = (dataWR == sfim_pkg::W4) ? {rxSh[3:0], lF} :
      ((dataWR == sfim_pkg::W2) ? {rxSh[5:0], lF[1:0]} : {rxSh[6:0], lF[1]});
   wire [3:0] rxBitsNext = rxBits + {1'b0, rxStep};
   wire [11:0] addrBeats = 12'({addrBytesR, 3'h0} >> addrWR);
   wire [11:0] dataBeats = 12'({bytesR, 3'h0} >> dataWR);
   wire sfim_pkg::sfim_phase_t afterAddr = (dummyR != 4'h0) ? sfim_pkg::PH_DUMMY :
      ((bytesR != 8'h0) ? sfim_pkg::PH_DATA : sfim_pkg::PH_END);

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= sfim_pkg::PH_IDLE;
         div <= 8'h0;
         txSh <= 40'h0;
         cnt <= 12'h0;
         rxSh <= 8'h0;
         rxBits <= 4'h0;
         rxDue <= 1'b0;
         dataSeen <= 1'b0;
         dummyR <= 4'h0;
         bytesR <= 8'h0;
         addrBytesR <= 3'h0;
         cmdWideR <= 1'b0;
         dtrR <= 1'b0;
         addrWR <= sfim_pkg::W1;
         dataWR <= sfim_pkg::W1;
         busy <= 1'b0;
         rdData <= 8'h0;
         rdValid <= 1'b0;
         holdActive <= 1'b0;
         resumeWait <= 8'h0;
         link.sclk <= 1'b0;
         link.csN <= 1'b1;
         link.hostOut <= sfim_pkg::RST_LANES;
         link.hostOe <= 4'h0;
      end else if (ce) begin
         rdValid <= 1'b0;
         // Pause only while selected, entered with the clock low
         holdActive <= holdReq & ~link.csN & ~quadUse & (holdActive | (~link.sclk & ~endTick));
         // Keep the clock still a half beat after release so the far end sees the pin first
         if (holdActive) begin
            resumeWait <= 8'(HALF_DIV);
         end else if (resumeWait != 8'h0) begin
            resumeWait <= 8'(resumeWait - 8'h1);
         end
         if (!quadUse && busy) begin
            link.hostOut[3] <= ~holdActive;
            link.hostOe[3] <= 1'b1;
         end
         if (run) begin
            div <= (div == DIV_END) ? 8'h0 : 8'(div + 8'h1);
         end
         if (state == sfim_pkg::PH_IDLE && start) begin
            busy <= 1'b1;
            div <= 8'h0;
            link.csN <= 1'b0;
            txSh <= (addrBytes == 3'h4) ? {instr, addr} : {instr, addr[23:0], 8'h0};
            addrBytesR <= addrBytes;
            cmdWideR <= cmdWide;
            addrWR <= cmdWide ? sfim_pkg::W4 : addrW;
            dataWR <= cmdWide ? sfim_pkg::W4 : dataW;
            dtrR <= dtr;
            dummyR <= dummyClks;
            bytesR <= readBytes;
            cnt <= cmdWide ? 12'h2 : 12'h8;
            dataSeen <= 1'b0;
            rxBits <= 4'h0;
            state <= sfim_pkg::PH_CMD;
         end
         // Launch mid-half so the far end samples stable data at the edge
         if (midTick && beat && txPhase) begin
            link.hostOut[2:0] <= txBits[2:0];
            if (quadUse) begin
               link.hostOut[3] <= txBits[3];
            end
            link.hostOe <= txOe | (quadUse ? 4'h0 : 4'h8);
            txSh <= txSh << txStep;
         end
         // Release the lanes a quarter beat after the last rising edge, never at the edge itself
         if (midTick && !txPhase) begin
            link.hostOe[2:0] <= 3'h0;
            if (quadUse) begin
               link.hostOe[3] <= 1'b0;
            end
         end
         // Capture a quarter beat after the beat, clear of the far end's next change
         if (midTick && rxDue) begin
            rxDue <= 1'b0;
            rxSh <= rxNext;
            rxBits <= (rxBitsNext == 4'h8) ? 4'h0 : rxBitsNext;
            if (rxBitsNext == 4'h8) begin
               rdData <= rxNext;
               rdValid <= 1'b1;
            end
         end
         if (endTick) begin
            link.sclk <= ~link.sclk;
            case (state)
               sfim_pkg::PH_CMD, sfim_pkg::PH_ADDR, sfim_pkg::PH_DUMMY, sfim_pkg::PH_DATA: begin
                  if ((state != sfim_pkg::PH_DUMMY && beat) || (state == sfim_pkg::PH_DUMMY && !link.sclk)) begin
                     cnt <= 12'(cnt - 12'h1);
                     if (state == sfim_pkg::PH_DATA) begin
                        rxDue <= 1'b1;
                        dataSeen <= 1'b1;
                     end
                     if (cnt == 12'h1) begin
                        if (state == sfim_pkg::PH_CMD) begin
                           state <= (addrBytesR == 3'h0) ? sfim_pkg::PH_END : sfim_pkg::PH_ADDR;
                           cnt <= addrBeats;
                        end else if (state == sfim_pkg::PH_ADDR) begin
                           state <= afterAddr;
                           cnt <= (dummyR != 4'h0) ? {8'h0, dummyR} : dataBeats;
                        end else if (state == sfim_pkg::PH_DUMMY) begin
                           state <= (bytesR != 8'h0) ? sfim_pkg::PH_DATA : sfim_pkg::PH_END;
                           cnt <= dataBeats;
                        end else begin
                           state <= sfim_pkg::PH_END;
                        end
                     end
                  end
               end
               sfim_pkg::PH_END: begin
                  link.sclk <= 1'b0;
                  link.csN <= 1'b1;
                  link.hostOe <= 4'h0;
                  state <= sfim_pkg::PH_SKIP;
               end
               default: begin
                  link.sclk <= 1'b0;
                  busy <= 1'b0;
                  state <= sfim_pkg::PH_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [sim/sfim_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sfim_props (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   // Link
   input wire logic sclk,
   input wire logic csN,
   input wire logic [3:0] hostOut,
   input wire logic [3:0] hostOe,
   input wire logic [3:0] devOe,
   input wire logic [3:0] lane
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // Host holds the pause pin low on a single or dual transfer
   sequence pause_held;
      !csN && hostOe[3] && !hostOe[2] && !lane[3];
   endsequence
   sequence pause_settled;
      pause_held [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   // Link relations
   desel_release_a: assert property (csN && $past(csN, 5) |-> devOe == 4'h0)
      else $error("device drives lanes while deselected");
   lane_group_a: assert property (devOe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("device lane enables form no valid group");
   no_contention_a: assert property ((hostOe & devOe) == 4'h0)
      else $error("host and device drive one lane together");
   idle_clock_a: assert property (csN |-> !sclk)
      else $error("serial clock not low while deselected");
   select_edge_a: assert property ($fell(csN) |-> !sclk && !$past(sclk))
      else $error("select fell with serial clock high");
   host_launch_a: assert property ($rose(sclk) && !csN |-> $stable(hostOut & hostOe))
      else $error("host data moved at a rising serial edge");
   pause_freeze_a: assert property (pause_held |-> !sclk && $stable(sclk))
      else $error("serial clock runs during pause");
   pause_release_a: assert property (pause_settled |-> devOe == 4'h0)
      else $error("device drives lanes while paused");
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, cmdWide = 1'b0, dtr = 1'b0, holdReq = 1'b0;
   logic quadLaneEnable = 1'b0, powerUpAddrMode = 1'b0, busy, rdValid, holdActive;
   logic addrStrobe, byteTaken, fourLaneCommandMode, currentAddrMode, paused;
   logic [7:0] instr = 8'h00, readBytes = 8'h00, readData = 8'h00, rdData, activeOp;
   logic [31:0] addr = 32'h12345678, address, capAddr = 32'h0;
   logic [2:0] addrBytes = 3'h0;
   logic [3:0] dummyClks = 4'h0;
   sfim_pkg::sfim_width_t addrW = sfim_pkg::W1, dataW = sfim_pkg::W1;
   int err_total = 0, checks = 0;
   sfim_link_if link ();
   sfim_device sfim_device_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .link(link),
      .quadLaneEnable(quadLaneEnable), .powerUpAddrMode(powerUpAddrMode), .extAddrReg(8'h3c),
      .readData(readData), .addrStrobe(addrStrobe), .address(address), .byteTaken(byteTaken), .activeOp(activeOp),
      .fourLaneCommandMode(fourLaneCommandMode), .currentAddrMode(currentAddrMode), .paused(paused));
   sfim_host sfim_host_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .link(link), .start(start), .instr(instr),
      .addr(addr), .addrBytes(addrBytes), .cmdWide(cmdWide), .addrW(addrW), .dataW(dataW), .dtr(dtr),
      .dummyClks(dummyClks), .readBytes(readBytes), .holdReq(holdReq), .busy(busy), .rdData(rdData),
      .rdValid(rdValid), .holdActive(holdActive));
   sfim_props sfim_props_inst (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .csN(link.csN),
      .hostOut(link.hostOut), .hostOe(link.hostOe), .devOe(link.devOe), .lane(link.lane));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and array side: each read starts a fresh byte pattern
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (start) begin
         capAddr <= 32'h0;
      end
      if (addrStrobe) begin
         capAddr <= address;
         readData <= 8'h5a;
      end else if (byteTaken) begin
         readData <= readData + 8'h11;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and one transfer; wm packs address and data width codes
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic stop_test;
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic xfer(input logic [7:0] op, input logic [2:0] ab, input logic wide, input logic [3:0] wm,
      input logic d, input logic [7:0] nb, input logic [31:0] expA);
      logic [7:0] k;
      logic [7:0] w;
      k = 8'h00;
      w = 8'h5a;
      @(posedge clk_sys);
      start <= 1'b1;
      instr <= op;
      addrBytes <= ab;
      cmdWide <= wide;
      addrW <= sfim_pkg::sfim_width_t'(wm[3:2]);
      dataW <= sfim_pkg::sfim_width_t'(wm[1:0]);
      dtr <= d;
      readBytes <= nb;
      dummyClks <= (op == 8'h03 || op == 8'h13 || nb == 8'h00) ? 4'h0 : 4'(sfim_pkg::DUMMY_CLKS);
      @(posedge clk_sys);
      start <= 1'b0;
      for (int n = 0; n < 6000; n++) begin
         @(negedge clk_sys);
         if (rdValid === 1'b1) begin
            chk({24'h0, rdData}, {24'h0, w});
            w = w + 8'h11;
            k = k + 8'h01;
         end
         if (busy !== 1'b1) break;
      end
      chk({31'h0, busy}, 32'h0);
      chk({24'h0, k}, {24'h0, nb});
      chk(capAddr, expA);
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(fourLaneCommandMode, 1'b0);
      chk(currentAddrMode, 1'b0);
      xfer(8'h03, 3'h3, 1'b0, 4'h0, 1'b0, 8'h02, 32'h3c345678);
      xfer(8'h13, 3'h4, 1'b0, 4'h0, 1'b0, 8'h02, 32'h12345678);
      xfer(8'h3b, 3'h3, 1'b0, 4'h1, 1'b0, 8'h02, 32'h3c345678);
      xfer(8'hbb, 3'h3, 1'b0, 4'h5, 1'b0, 8'h02, 32'h3c345678);
      xfer(8'h0d, 3'h3, 1'b0, 4'h0, 1'b1, 8'h02, 32'h3c345678);
      xfer(8'h6b, 3'h3, 1'b0, 4'h2, 1'b0, 8'h00, 32'h0);
      xfer(8'h38, 3'h0, 1'b0, 4'h0, 1'b0, 8'h00, 32'h0);
      chk(fourLaneCommandMode, 1'b0);
      fork
         xfer(8'h0b, 3'h3, 1'b0, 4'h0, 1'b0, 8'h02, 32'h3c345678);
         begin
            repeat (700) @(posedge clk_sys);
            holdReq <= 1'b1;
            repeat (100) @(posedge clk_sys);
            chk(paused, 1'b1);
            chk(holdActive, 1'b1);
            holdReq <= 1'b0;
            repeat (40) @(posedge clk_sys);
            chk(paused, 1'b0);
         end
      join
      quadLaneEnable <= 1'b1;
      xfer(8'h6b, 3'h3, 1'b0, 4'h2, 1'b0, 8'h02, 32'h3c345678);
      xfer(8'heb, 3'h3, 1'b0, 4'ha, 1'b0, 8'h02, 32'h3c345678);
      xfer(8'hb7, 3'h0, 1'b0, 4'h0, 1'b0, 8'h00, 32'h0);
      chk(currentAddrMode, 1'b1);
      xfer(8'h0b, 3'h4, 1'b0, 4'h0, 1'b0, 8'h02, 32'h12345678);
      xfer(8'h38, 3'h0, 1'b0, 4'h0, 1'b0, 8'h00, 32'h0);
      chk(fourLaneCommandMode, 1'b1);
      xfer(8'h0b, 3'h4, 1'b1, 4'ha, 1'b0, 8'h02, 32'h12345678);
      xfer(8'hff, 3'h0, 1'b1, 4'ha, 1'b0, 8'h00, 32'h0);
      chk(fourLaneCommandMode, 1'b0);
      xfer(8'h38, 3'h0, 1'b0, 4'h0, 1'b0, 8'h00, 32'h0);
      xfer(8'h99, 3'h0, 1'b1, 4'ha, 1'b0, 8'h00, 32'h0);
      chk(fourLaneCommandMode, 1'b0);
      chk(currentAddrMode, 1'b0);
      chk({24'h0, activeOp}, 32'h99);
      powerUpAddrMode <= 1'b1;
      rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(currentAddrMode, 1'b1);
      stop_test;
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      stop_test;
   end
endmodule
`default_nettype wire
